// ===== acs_pkg.sv
// acs_pkg: constants and types of the converter sequencer
// assumes a 200 MHz system clock and a 32-bit classic wishbone bus
`default_nettype none
package acs_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] RESULT_OFS = 8'h04;
	localparam logic [7:0] REFPRG_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS   = 8'h0C;
	localparam logic [7:0] MASK_OFS   = 8'h10;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_CHAN_LSB = 0;
	localparam int CTRL_CONT_BIT = 3;
	localparam int CTRL_BUSY_BIT = 4;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_ABRT_BIT = 1;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [7:0] REFPRG_RST = 8'h00;
	localparam logic [1:0] IRQ_RST    = 2'h0;

	// ----------------------------------------
	// conversion timing
	// ----------------------------------------
	localparam int MC_TIME_NS    = 1000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int MC_CLKS       = MC_TIME_NS / CLK_PERIOD_NS;
	localparam logic [7:0] MC_LAST   = 8'(MC_CLKS - 1);
	localparam logic [3:0] STEP_IDLE = 4'h0;
	localparam logic [3:0] STEP_TRK0 = 4'h1;
	localparam logic [3:0] STEP_TRK1 = 4'h5;
	localparam logic [3:0] STEP_SAR0 = 4'h6;
	localparam logic [3:0] STEP_BIT0 = 4'h7;
	localparam logic [3:0] STEP_BIT7 = 4'hE;
	localparam logic [3:0] STEP_DONE = 4'hF;
	localparam logic [7:0] SAR_MSB   = 8'h80;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic       cont;
		logic [2:0] chan;
	} acs_ctrl_t;

	typedef struct packed {
		logic [3:0] upper;
		logic [3:0] lower;
	} acs_ref_t;

endpackage
`default_nettype wire

// ===== acs_top.sv
// acs_top: sequencer for an 8-bit successive-approximation converter
// assumes an external dac, comparator, sample-and-hold and eight-way mux
//
// Notes on behaviour
// - each write to the reference program register starts a conversion on the chosen channel.
// - a write during a running conversion aborts it and starts again from the beginning.
// - the sequence begins in the machine cycle right after the write.
// - the busy flag is set in the machine cycle of the write itself.
// - with a zero reference value the conversion takes fifteen machine cycles.
// - the sample-and-hold tracks for the first five machine cycles and then holds.
// - the approximation steps run from the sixth to the fifteenth machine cycle.
// - the 8-bit result is moved into the result register in the fifteenth cycle.
// - the result register keeps its value until a later result is written.
// - software may both read and write the result register.
// - the channel field of the control register routes one of eight inputs.
// - a control bit chooses single or continuous conversion.
// - the control register shows a readable busy bit.
// - the reference value sets the internal references; zero selects the external ones.
// - each sample is resolved to 8 bits by a binary search through the dac.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acs_top
	import acs_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        cmp_above,
	output logic      [2:0]  mux_sel,
	output logic             sh_track,
	output logic      [7:0]  dac_code,
	output acs_ref_t         ref_code,
	output logic             ref_external,
	output logic             irq
);

	// ----------------------------------------
	// comparator synchroniser
	// ----------------------------------------
	logic cmp_meta_ff;
	logic cmp_sync_ff;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmp_meta_ff <= 1'b0;
			cmp_sync_ff <= 1'b0;
		end
		else
		begin
			cmp_meta_ff <= cmp_above;
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	logic        ack_ff;
	logic        nxt_ack;
	logic [31:0] rdat_ff;
	logic [31:0] nxt_rdat;
	logic        bus_take;
	logic        wr_ctrl;
	logic        wr_res;
	logic        wr_ref;
	logic        wr_mask;
	logic        rd_stat;

	acs_ctrl_t   ctrl_ff;
	logic [7:0]  result_ff;
	acs_ref_t    refprg_ff;
	logic        ref_ext_ff;
	logic        busy_ff;
	logic [1:0]  stat_ff;
	logic [1:0]  mask_ff;

	// the access completes on the edge where ack is already high
	assign bus_take = wb_cyc_i && wb_stb_i && ack_ff;
	assign wr_ctrl  = bus_take && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS;
	assign wr_res   = bus_take && wb_we_i && wb_sel_i[0] && wb_adr_i == RESULT_OFS;
	assign wr_ref   = bus_take && wb_we_i && wb_sel_i[0] && wb_adr_i == REFPRG_OFS;
	assign wr_mask  = bus_take && wb_we_i && wb_sel_i[0] && wb_adr_i == MASK_OFS;
	assign rd_stat  = bus_take && !wb_we_i && wb_adr_i == STAT_OFS;

	always_comb
	begin
		nxt_ack  = wb_cyc_i && wb_stb_i && !ack_ff;
		nxt_rdat = 32'h0;
		case (wb_adr_i)
			CTRL_OFS:
			begin
				nxt_rdat[2:0]           = ctrl_ff.chan;
				nxt_rdat[CTRL_CONT_BIT] = ctrl_ff.cont;
				nxt_rdat[CTRL_BUSY_BIT] = busy_ff;
			end
			RESULT_OFS: nxt_rdat[7:0] = result_ff;
			REFPRG_OFS: nxt_rdat[7:0] = refprg_ff;
			STAT_OFS:   nxt_rdat[1:0] = stat_ff;
			MASK_OFS:   nxt_rdat[1:0] = mask_ff;
			default:    nxt_rdat = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0;
		end
		else
		begin
			ack_ff  <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// ----------------------------------------
	// machine cycle divider
	// ----------------------------------------
	logic [7:0] div_ff;
	logic [7:0] nxt_div;
	logic       mc_tick;

	assign mc_tick = div_ff == MC_LAST;

	always_comb
	begin
		nxt_div = mc_tick ? 8'h00 : div_ff + 8'h01;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			div_ff <= 8'h00;
		else
			div_ff <= nxt_div;
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	logic [3:0]  step_ff;
	logic [3:0]  nxt_step;
	logic [7:0]  sar_ff;
	logic [7:0]  nxt_sar;
	logic [7:0]  bit_ff;
	logic [7:0]  nxt_bit;
	logic        nxt_busy;
	logic        trk_ff;
	logic        nxt_trk;
	logic [7:0]  nxt_result;
	acs_ctrl_t   nxt_ctrl;
	acs_ref_t    nxt_refprg;
	logic        nxt_ref_ext;
	logic        done_ev;
	logic        abort_ev;

	// the last step only finishes while no new start overrides it
	assign done_ev  = busy_ff && mc_tick && step_ff == STEP_DONE && !wr_ref;
	assign abort_ev = wr_ref && busy_ff;

	always_comb
	begin
		nxt_step    = step_ff;
		nxt_sar     = sar_ff;
		nxt_bit     = bit_ff;
		nxt_busy    = busy_ff;
		nxt_result  = result_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_refprg  = refprg_ff;
		nxt_ref_ext = ref_ext_ff;
		if (wr_ctrl)
		begin
			nxt_ctrl.chan = wb_dat_i[2:0];
			nxt_ctrl.cont = wb_dat_i[CTRL_CONT_BIT];
		end
		if (wr_res)
			nxt_result = wb_dat_i[7:0];
		if (wr_ref)
		begin
			// a write restarts even a running conversion
			nxt_refprg  = wb_dat_i[7:0];
			nxt_ref_ext = wb_dat_i[7:0] == 8'h00;
			nxt_busy    = 1'b1;
			nxt_step    = STEP_IDLE;
			nxt_sar     = 8'h00;
			nxt_bit     = 8'h00;
		end
		else if (busy_ff && mc_tick)
		begin
			case (step_ff)
				STEP_SAR0:
				begin
					nxt_sar  = SAR_MSB;
					nxt_bit  = SAR_MSB;
					nxt_step = step_ff + 4'h1;
				end
				STEP_DONE:
				begin
					// result wins over a software write in the same cycle
					nxt_result = sar_ff;
					nxt_sar    = 8'h00;
					nxt_bit    = 8'h00;
					if (ctrl_ff.cont)
						nxt_step = STEP_TRK0;
					else
					begin
						nxt_step = STEP_IDLE;
						nxt_busy = 1'b0;
					end
				end
				default:
				begin
					if (step_ff >= STEP_BIT0 && step_ff <= STEP_BIT7)
					begin
						// drop the trial bit when the input is below the dac
						if (!cmp_sync_ff)
							nxt_sar = (sar_ff & ~bit_ff) | (bit_ff >> 1);
						else
							nxt_sar = sar_ff | (bit_ff >> 1);
						nxt_bit = bit_ff >> 1;
					end
					nxt_step = step_ff + 4'h1;
				end
			endcase
		end
		// track only in steps one to five
		nxt_trk = nxt_busy && nxt_step >= STEP_TRK0 && nxt_step <= STEP_TRK1;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			step_ff    <= STEP_IDLE;
			sar_ff     <= 8'h00;
			bit_ff     <= 8'h00;
			busy_ff    <= 1'b0;
			trk_ff     <= 1'b0;
			result_ff  <= RESULT_RST;
			ctrl_ff    <= '0;
			refprg_ff  <= REFPRG_RST;
			ref_ext_ff <= 1'b1;
		end
		else
		begin
			step_ff    <= nxt_step;
			sar_ff     <= nxt_sar;
			bit_ff     <= nxt_bit;
			busy_ff    <= nxt_busy;
			trk_ff     <= nxt_trk;
			result_ff  <= nxt_result;
			ctrl_ff    <= nxt_ctrl;
			refprg_ff  <= nxt_refprg;
			ref_ext_ff <= nxt_ref_ext;
		end
	end

	assign mux_sel      = ctrl_ff.chan;
	assign sh_track     = trk_ff;
	assign dac_code     = sar_ff;
	assign ref_code     = refprg_ff;
	assign ref_external = ref_ext_ff;

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	logic [1:0] nxt_stat;
	logic [1:0] nxt_mask;
	logic       irq_ff;
	logic       nxt_irq;

	always_comb
	begin
		nxt_stat = stat_ff;
		nxt_mask = mask_ff;
		if (rd_stat)
			nxt_stat = 2'h0;
		// a new event in the clearing cycle is kept
		if (done_ev)
			nxt_stat[STAT_DONE_BIT] = 1'b1;
		if (abort_ev)
			nxt_stat[STAT_ABRT_BIT] = 1'b1;
		if (wr_mask)
			nxt_mask = wb_dat_i[1:0];
		nxt_irq = |(nxt_stat & nxt_mask);
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stat_ff <= IRQ_RST;
			mask_ff <= IRQ_RST;
			irq_ff  <= 1'b0;
		end
		else
		begin
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			irq_ff  <= nxt_irq;
		end
	end

	assign irq = irq_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence start_seq;
		wr_ref;
	endsequence

	sequence last_step_seq;
		done_ev && !wr_res;
	endsequence

	busy_on_write_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		start_seq |=> busy_ff && step_ff == STEP_IDLE)
		else $error("busy not set by reference write");

	restart_abort_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		busy_ff && step_ff > STEP_IDLE && wr_ref |=> step_ff == STEP_IDLE && stat_ff[1])
		else $error("running conversion not restarted");

	first_step_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		start_seq ##1 (!wr_ref && !mc_tick)[*1] |-> step_ff == STEP_IDLE)
		else $error("sequence began inside the write cycle");

	step_range_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		busy_ff && mc_tick && step_ff == STEP_IDLE && !wr_ref |=> step_ff == STEP_TRK0)
		else $error("step one not entered after start");

	track_hold_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		step_ff >= STEP_SAR0 |-> !sh_track)
		else $error("tracking after step five");

	sar_window_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		busy_ff && step_ff < STEP_BIT0 && !wr_ref && !(mc_tick && step_ff == STEP_SAR0)
		|=> $stable(dac_code))
		else $error("approximation outside its window");

	result_load_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		last_step_seq |=> result_ff == $past(sar_ff) && stat_ff[0])
		else $error("result not transferred in last step");

	result_hold_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		!done_ev && !wr_res |=> $stable(result_ff))
		else $error("result changed without a cause");

	busy_clear_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(last_step_seq and !ctrl_ff.cont) |=> !busy_ff ##1 (!busy_ff || $past(wr_ref)))
		else $error("busy kept after single conversion");

	cont_restart_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(last_step_seq and (ctrl_ff.cont && !wr_ctrl))
		|=> busy_ff && step_ff == STEP_TRK0 && sh_track)
		else $error("continuous mode did not restart");

	ref_ext_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		start_seq |=> ref_external == (ref_code == 8'h00))
		else $error("external reference choice wrong");

	irq_level_a: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		done_ev && mask_ff[0] && !wr_mask |=> irq)
		else $error("masked-in event gave no interrupt");

endmodule
`default_nettype wire

// ===== acs_src_model.sv
// acs_src_model: eight analog sources, sample-and-hold and comparator
// assumes the sequencer drives mux_sel, sh_track and dac_code
`timescale 1ns/1ps
`default_nettype none
module acs_src_model
(
	input  wire logic       sys_clk,
	input  wire logic       drift,
	input  wire logic [2:0] mux_sel,
	input  wire logic       sh_track,
	input  wire logic [7:0] dac_code,
	output logic            cmp_above
);
	logic [7:0] held = 8'h00;
	// drift flips every live level, so a leaky hold shows in the result
	function automatic logic [7:0] live(input logic [2:0] ch);
		return (8'h17 + 8'(ch) * 8'h1D) ^ {8{drift}};
	endfunction
	always @(posedge sys_clk)
		if (sh_track)
			held <= live(mux_sel);
	// half an lsb above held, so the search settles on held itself
	assign cmp_above = {held, 1'b1} > {dac_code, 1'b0};
endmodule
`default_nettype wire

// ===== tb_top.sv
// tb_top: self-checking bench for the converter sequencer
// assumes acs_pkg and the analog source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import acs_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        arst_n  = 1'b0;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic        drift   = 1'b0;
	logic [7:0]  adr     = 8'h00;
	logic [31:0] dat     = 32'h0;
	logic [31:0] dat_o;
	logic        ack;
	logic        cmp;
	logic [2:0]  mux;
	logic        sht;
	logic [7:0]  dac;
	acs_ref_t    refc;
	logic        refx;
	logic        irq;
	int          n_errors  = 0;
	int          tests_run = 0;
	int          n;
	int          tr;

	always #2.5 sys_clk = ~sys_clk;

	acs_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .cmp_above(cmp), .mux_sel(mux), .sh_track(sht), .dac_code(dac),
		.ref_code(refc), .ref_external(refx), .irq(irq));
	acs_src_model src_u (.sys_clk(sys_clk), .drift(drift), .mux_sel(mux),
		.sh_track(sht), .dac_code(dac), .cmp_above(cmp));

	// ----------------------------------------
	// bus and check helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		// ack and data are read as they stood at the edge; only the watchdog ends a hang
		do
			@(posedge sys_clk);
		while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask

	function automatic logic [31:0] lvl(input logic [2:0] ch);
		return 32'(8'h17 + 8'(ch) * 8'h1D);
	endfunction

	// counts clocks until irq, and the clocks spent tracking
	task automatic wait_done();
		n = 0;
		tr = 0;
		while (irq !== 1'b1 && n < 4000)
		begin
			@(negedge sys_clk);
			n++;
			tr += int'(sht === 1'b1);
			drift = (n > 1300 && n < 2900);
		end
		check(32'(n >= 2990 && n <= 3205), 32'h1);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(32'(refx), 32'h1);
		rd(RESULT_OFS, 32'(RESULT_RST));
		rd(CTRL_OFS, 32'h0);
		rd(8'h20, 32'h0);
	endtask

	task automatic t_single();
		wr(MASK_OFS, 32'h1);
		wr(CTRL_OFS, 32'h5);
		wr(REFPRG_OFS, 32'h0);
		rd(CTRL_OFS, 32'h15);
		check(32'(mux), 32'h5);
		wait_done();
		check(32'(tr), 32'h3E8);
		rd(STAT_OFS, 32'h1);
		@(posedge sys_clk);
		@(negedge sys_clk);
		check(32'(irq), 32'h0);
		rd(CTRL_OFS, 32'h5);
		rd(RESULT_OFS, lvl(3'h5));
	endtask

	task automatic t_abort();
		wr(REFPRG_OFS, 32'h3C);
		repeat (600) @(posedge sys_clk);
		check(32'(refc), 32'h3C);
		check(32'(refx), 32'h0);
		wr(REFPRG_OFS, 32'h0);
		wait_done();
		rd(STAT_OFS, 32'h3);
		rd(STAT_OFS, 32'h0);
		check(32'(refx), 32'h1);
	endtask

	task automatic t_result_rw();
		wr(RESULT_OFS, 32'hA5);
		rd(RESULT_OFS, 32'hA5);
		repeat (400) @(posedge sys_clk);
		rd(RESULT_OFS, 32'hA5);
	endtask

	task automatic t_cont();
		wr(CTRL_OFS, 32'hA);
		wr(REFPRG_OFS, 32'h0);
		wait_done();
		rd(STAT_OFS, 32'h1);
		rd(RESULT_OFS, lvl(3'h2));
		wait_done();
		rd(STAT_OFS, 32'h1);
		rd(CTRL_OFS, 32'h1A);
		wr(CTRL_OFS, 32'h2);
		wait_done();
		rd(STAT_OFS, 32'h1);
		rd(CTRL_OFS, 32'h2);
	endtask

	task automatic t_masked();
		wr(MASK_OFS, 32'h0);
		wr(REFPRG_OFS, 32'h0);
		repeat (3400) @(posedge sys_clk);
		check(32'(irq), 32'h0);
		rd(STAT_OFS, 32'h1);
		rd(MASK_OFS, 32'h0);
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_single();
		t_abort();
		t_result_rw();
		t_cont();
		t_masked();
		print_verdict();
	end

	// about six conversions of 16 us each, with ample margin
	initial
	begin
		#400000;
		n_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
